// ### logic/hbdfc_top.sv
// h-bridge direction decoding, fault latch, soft-start and sleep control
`timescale 1ns/10ps
module hbdfc_top
    import hbdfc_pkg::*;
#(
    parameter int unsigned SLEEP_COUNT = SLEEP_CYC,  // braking cycles before sleep
    parameter int unsigned CLEAR_COUNT = CLEAR_CYC   // both-low cycles to clear fault
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic              legASelect,     // pin, leg a drive request
    input  wire logic              legBSelect,     // pin, leg b drive request
    input  wire hbdfc_trips_t      trips,          // pins from analog detectors
    input  wire logic [RAMP_W-1:0] rampLevel,      // digitised soft-start ramp
    output hbdfc_gates_t           gates,          // four gate drives
    output logic                   faultFlagOut,   // open-drain flag, driven value
    output logic                   faultFlagOe_n,  // low while pulling the flag low
    output logic                   rampDischarge,  // soft-start reset switch
    output logic                   rampSupplyOn,   // internal ramp supply, off in sleep
    output logic                   sleeping        // low consumption state
);

    //--------------------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------------------
    logic [4:0] syncA_ff;        // first stage, read by second stage only
    logic [4:0] syncB_ff;        // second stage, safe to use
    logic [4:0] nxt_syncA;
    logic [4:0] nxt_syncB;
    logic       selA;
    logic       selB;
    hbdfc_trips_t trip;

    // two flops on every asynchronous pin
    always_comb
    begin
        nxt_syncA = {legASelect, legBSelect, trips};
        nxt_syncB = syncA_ff;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            syncA_ff <= 5'h00;
            syncB_ff <= 5'h00;
        end
        else if (clkEn)
        begin
            syncA_ff <= nxt_syncA;
            syncB_ff <= nxt_syncB;
        end
    end

    assign selA = syncB_ff[4];
    assign selB = syncB_ff[3];
    assign trip = hbdfc_trips_t'(syncB_ff[2:0]);

    //--------------------------------------------------------------------------
    // mode decode
    //--------------------------------------------------------------------------
    hbdfc_mode_t mode;

    // a forward of the truth table is leg b high side on
    always_comb
    begin
        case ({selA, selB})
            2'b00:   mode = HBDFC_BRAKE;
            2'b01:   mode = HBDFC_FWD;
            2'b10:   mode = HBDFC_REV;
            2'b11:   mode = HBDFC_COAST;
            default: mode = HBDFC_BRAKE;
        endcase
    end

    //--------------------------------------------------------------------------
    // fault latch and sleep timer
    //--------------------------------------------------------------------------
    logic        fault_ff;       // latched protection trip
    logic        nxt_fault;
    logic [31:0] lowCnt_ff;      // cycles with both selects low
    logic [31:0] nxt_lowCnt;
    logic        sleep_ff;
    logic        nxt_sleep;
    logic        tripNow;

    // protections watch in every mode but brake, coast included; braking current is not monitored
    assign tripNow = (mode != HBDFC_BRAKE) &&                   // see [R11]
                     (trip.overTemp | trip.overCurA | trip.overCurB);  // see [R8]

    always_comb
    begin
        nxt_lowCnt = lowCnt_ff;
        nxt_fault  = fault_ff;
        nxt_sleep  = sleep_ff;
        if (mode != HBDFC_BRAKE)
        begin
            nxt_lowCnt = 32'h0000_0000;                         // see [R20]
            nxt_sleep  = 1'b0;                                  // see [R20]
        end
        else if (lowCnt_ff < 32'(SLEEP_COUNT))
        begin
            nxt_lowCnt = lowCnt_ff + 32'h0000_0001;
        end
        // clear only after the both-low hold; a trip cannot occur in brake
        if ((mode == HBDFC_BRAKE) && (lowCnt_ff >= 32'(CLEAR_COUNT) - 32'h1))
        begin
            nxt_fault = 1'b0;                                   // see [R10]
        end
        if (tripNow)
        begin
            nxt_fault = 1'b1;                                   // see [R8]
        end
        if ((mode == HBDFC_BRAKE) && (lowCnt_ff >= 32'(SLEEP_COUNT) - 32'h1))
        begin
            nxt_sleep = 1'b1;                                   // see [R12]
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_ff  <= FAULT_RST;
            lowCnt_ff <= 32'h0000_0000;
            sleep_ff  <= SLEEP_RST;
        end
        else if (clkEn)
        begin
            fault_ff  <= nxt_fault;
            lowCnt_ff <= nxt_lowCnt;
            sleep_ff  <= nxt_sleep;
        end
    end

    //--------------------------------------------------------------------------
    // soft-start pwm
    //--------------------------------------------------------------------------
    logic pwmOn;

    hbdfc_pwm #(
        .PERIOD    (OSC_CYC)
    ) uPwm (
        .clk       (clk),
        .nrst      (nrst),
        .clkEn     (clkEn),
        .rampLevel (rampLevel),
        .pwmOn     (pwmOn)
    );

    //--------------------------------------------------------------------------
    // gate decode and output registers
    //--------------------------------------------------------------------------
    hbdfc_gates_t gates_ff;
    hbdfc_gates_t nxt_gates;
    logic         flagLow_ff;    // pulling the flag low
    logic         nxt_flagLow;
    logic         disch_ff;
    logic         nxt_disch;
    logic         supply_ff;
    logic         nxt_supply;
    logic         faultNow;

    // a fresh trip acts in the same cycle it is latched
    assign faultNow = fault_ff | tripNow;

    // one registered decode; outputs follow a select change on the next edge
    always_comb
    begin
        nxt_gates   = '0;
        nxt_flagLow = 1'b0;
        nxt_disch   = 1'b0;
        case (mode)
            HBDFC_BRAKE:
            begin
                nxt_gates.lowA = 1'b1;                          // see [R2]
                nxt_gates.lowB = 1'b1;                          // see [R12]
                nxt_disch      = 1'b1;                          // see [R13]
            end
            HBDFC_FWD:
            begin
                // low a gated by pwm, high a off: no overlap in leg a
                nxt_gates.lowA  = pwmOn;                        // see [R1]
                nxt_gates.highB = !faultNow;                    // see [R3]
                nxt_flagLow     = faultNow;                     // see [R4]
            end
            HBDFC_REV:
            begin
                nxt_gates.lowB  = pwmOn;                        // see [R1]
                nxt_gates.highA = !faultNow;                    // see [R5]
                nxt_flagLow     = faultNow;                     // see [R6]
            end
            HBDFC_COAST:
            begin
                nxt_disch = 1'b1;                               // see [R7]
            end
            default:
            begin
                nxt_gates.lowA = 1'b1;
                nxt_gates.lowB = 1'b1;
            end
        endcase
        // fault kills high sides only, never forces a brake
        if (faultNow)
        begin
            nxt_gates.highA = 1'b0;                             // see [R9]
            nxt_gates.highB = 1'b0;                             // see [R9]
        end
        // mode change re-evaluates the ramp path immediately
        nxt_supply = !nxt_sleep;                                // see [R16]
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gates_ff   <= '0;
            flagLow_ff <= 1'b0;
            disch_ff   <= 1'b1;
            supply_ff  <= 1'b1;
        end
        else if (clkEn)
        begin
            gates_ff   <= nxt_gates;
            flagLow_ff <= nxt_flagLow;
            disch_ff   <= nxt_disch;
            supply_ff  <= nxt_supply;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign gates         = gates_ff;
    assign faultFlagOut  = 1'b0;
    assign faultFlagOe_n = !flagLow_ff;
    assign rampDischarge = disch_ff;
    assign rampSupplyOn  = supply_ff;
    assign sleeping      = sleep_ff;

endmodule : hbdfc_top

// ### logic/hbdfc_pkg.sv
// package of constants and carrier types for the h-bridge direction and fault control
//------------------------------------------------------------------------------
// Overview of operation
// [R1] each select input drives one leg, no overlap
// [R2] both low: brake, low sides on, discharge
// [R3] b selected: high b, low a on
// [R4] forward fault: flag low, high b off
// [R5] a selected: high a, low b on
// [R6] reverse fault: flag low, high a off
// [R7] both high: all gates off, coast
// [R8] temperature or leg current trip latches fault
// [R9] fault turns high sides off, no brake
// [R10] fault clears after both low minimum time
// [R11] braking standby keeps protections inactive
// [R12] sleep after 300 ms braking, low sides on
// [R13] equal inputs discharge the soft-start ramp
// [R14] active low side switches at 20 kHz
// [R15] external ramp clock stays below 20 kHz
// [R16] input change aborts ramp at any time; a direct forward/reverse swap leaves the discharge off here
// [R17] controller waits before reversing or restarting
// [R18] end switch inputs need external debouncing
// [R19] no pulses below 1.2V, solid above 4.2V
// [R20] leaving low inputs wakes and restarts timer
//------------------------------------------------------------------------------
package hbdfc_pkg;

    // timing
    localparam int unsigned CLK_HZ         = 25_000_000;  // system clock rate
    localparam int unsigned OSC_HZ         = 20_000;      // pwm oscillator rate
    localparam int unsigned OSC_CYC        = CLK_HZ / OSC_HZ;  // 1250 cycles per period
    localparam int unsigned SLEEP_MS       = 300;         // braking time before sleep
    localparam int unsigned SLEEP_CYC      = SLEEP_MS * (CLK_HZ / 1000);
    localparam int unsigned CLEAR_US       = 100;         // least both-low time to clear fault
    localparam int unsigned CLEAR_CYC      = CLEAR_US * (CLK_HZ / 1_000_000);
    // ramp scale: ramp code full range equals 5 V, millivolts per step 5000/256
    localparam int unsigned RAMP_W         = 8;
    localparam int unsigned RAMP_LO_MV     = 1200;        // below: no pulses
    localparam int unsigned RAMP_HI_MV     = 4200;        // above: solid on
    localparam int unsigned RAMP_FS_MV     = 5000;        // full-scale ramp code
    localparam logic [7:0]  RAMP_LO_CODE   = 8'((RAMP_LO_MV * 256) / RAMP_FS_MV);
    localparam logic [7:0]  RAMP_HI_CODE   = 8'((RAMP_HI_MV * 256) / RAMP_FS_MV);
    // reset values
    localparam logic        FAULT_RST      = 1'b0;
    localparam logic        SLEEP_RST      = 1'b0;

    // operating modes from the two select inputs
    typedef enum logic [1:0] {
        HBDFC_BRAKE,
        HBDFC_FWD,
        HBDFC_REV,
        HBDFC_COAST
    } hbdfc_mode_t;

    // four gate drives travel together
    typedef struct packed {
        logic highA;
        logic highB;
        logic lowA;
        logic lowB;
    } hbdfc_gates_t;

    // protection trip inputs
    typedef struct packed {
        logic overTemp;
        logic overCurA;
        logic overCurB;
    } hbdfc_trips_t;

endpackage : hbdfc_pkg

// ### logic/hbdfc_pwm.sv
// ramp versus sawtooth comparator that gates the active low-side switch
`timescale 1ns/10ps
module hbdfc_pwm
    import hbdfc_pkg::*;
#(
    parameter int unsigned PERIOD = OSC_CYC  // clock cycles per oscillator period
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic [RAMP_W-1:0] rampLevel,
    output logic                   pwmOn
);

    //--------------------------------------------------------------------------
    // sawtooth oscillator
    //--------------------------------------------------------------------------
    logic [15:0] sawCnt_ff;      // position inside the period
    logic [15:0] nxt_sawCnt;
    logic        pwmOn_ff;       // comparator result
    logic        nxt_pwmOn;
    logic [RAMP_W-1:0] sawLvl;   // saw mapped onto the ramp scale
    logic [31:0] sawProd;        // wide product, avoids overflow

    // free running count, wraps once per 20 kHz period
    always_comb
    begin
        nxt_sawCnt = (sawCnt_ff >= 16'(PERIOD - 1)) ? 16'h0000 : sawCnt_ff + 16'h0001;
        sawProd    = 32'(sawCnt_ff) * 32'(RAMP_HI_CODE - RAMP_LO_CODE);
        // saw spans low to high threshold so duty runs 0..100 % between them
        sawLvl     = RAMP_W'(32'(RAMP_LO_CODE) + sawProd / 32'(PERIOD));
        if (rampLevel < RAMP_LO_CODE)
        begin
            nxt_pwmOn = 1'b0;                                   // see [R19]
        end
        else if (rampLevel > RAMP_HI_CODE)
        begin
            nxt_pwmOn = 1'b1;                                   // see [R19]
        end
        else
        begin
            nxt_pwmOn = rampLevel > sawLvl;                     // see [R14]
        end
    end

    // registers only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sawCnt_ff <= 16'h0000;
            pwmOn_ff  <= 1'b0;
        end
        else if (clkEn)
        begin
            sawCnt_ff <= nxt_sawCnt;
            pwmOn_ff  <= nxt_pwmOn;
        end
    end

    assign pwmOn = pwmOn_ff;

endmodule : hbdfc_pwm

// ### test/hbdfc_checker.sv
// assertion checker bound to the h-bridge control top
`timescale 1ns/10ps
module hbdfc_checker
    import hbdfc_pkg::*;
#(
    parameter int unsigned SLEEP_COUNT = SLEEP_CYC,  // braking cycles to sleep
    parameter int unsigned CLEAR_COUNT = CLEAR_CYC   // both-low cycles to clear
)(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              clkEn,
    input wire logic              legASelect,
    input wire logic              legBSelect,
    input wire hbdfc_trips_t      trips,
    input wire logic [RAMP_W-1:0] rampLevel,
    input wire hbdfc_gates_t      gates,
    input wire logic              faultFlagOut,
    input wire logic              faultFlagOe_n,
    input wire logic              rampDischarge,
    input wire logic              rampSupplyOn,
    input wire logic              sleeping
);
    // --------------------------------------
    // helper logic
    // --------------------------------------
    logic        drv;     // a leg is requested
    int unsigned lowCnt;  // run of both-low samples
    logic        faultHeld;  // flag seen low, not yet cleared by braking

    assign drv = legASelect | legBSelect;

    // raw run length; the design sees it two edges late, hence the slack below
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lowCnt <= 0;
        else
            lowCnt <= drv ? 0 : lowCnt + 1;
    end

    // flag low means latched; only a long enough both-low run releases it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            faultHeld <= 1'b0;
        else if (!faultFlagOe_n)
            faultHeld <= 1'b1;
        else if (lowCnt >= CLEAR_COUNT)
            faultHeld <= 1'b0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // --------------------------------------
    // properties; four steady samples cover sync plus output flop
    // --------------------------------------
    property p_brake;
        (!drv)[*4] |-> gates == 4'h3 && rampDischarge;
    endproperty
    a_brake: assert property (p_brake) else $error("brake outputs");
    property p_fwd;
        (!legASelect && legBSelect)[*4] |-> !gates.highA && !gates.lowB
            && gates.highB == faultFlagOe_n && !rampDischarge;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward outputs");
    property p_rev;
        (legASelect && !legBSelect)[*4] |-> !gates.highB && !gates.lowA
            && gates.highA == faultFlagOe_n && !rampDischarge;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse outputs");
    property p_coast;
        (legASelect && legBSelect)[*4] |-> gates == 4'h0 && rampDischarge;
    endproperty
    a_coast: assert property (p_coast) else $error("coast outputs");
    property p_trip;
        (drv && trips != 3'h0)[*3] |-> ##[0:3] !faultFlagOe_n;
    endproperty
    a_trip: assert property (p_trip) else $error("trip not flagged");
    property p_idle;
        $fell(faultFlagOe_n) |-> $past(drv, 2) || $past(drv, 3) || $past(drv, 4);
    endproperty
    a_idle: assert property (p_idle) else $error("fault while braking");
    // the flag itself is released in braking, so watch the high sides on the next drive
    property p_clear;
        (faultHeld && legASelect != legBSelect)[*4] |-> !gates.highA && !gates.highB;
    endproperty
    a_clear: assert property (p_clear) else $error("fault cleared early");
    property p_sleep;
        lowCnt == SLEEP_COUNT + 6 |-> sleeping && !rampSupplyOn && gates == 4'h3;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_wake;
        sleeping && drv |-> ##[1:5] !sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule : hbdfc_checker

bind hbdfc_top hbdfc_checker #(.SLEEP_COUNT(SLEEP_COUNT), .CLEAR_COUNT(CLEAR_COUNT))
    u_hbdfc_checker (.clk(clk), .nrst(nrst), .clkEn(clkEn), .legASelect(legASelect),
    .legBSelect(legBSelect), .trips(trips), .rampLevel(rampLevel), .gates(gates),
    .faultFlagOut(faultFlagOut), .faultFlagOe_n(faultFlagOe_n),
    .rampDischarge(rampDischarge), .rampSupplyOn(rampSupplyOn), .sleeping(sleeping));

// ### test/hbdfc_ctrl_model.sv
// controller model turning a mode request into clean select levels
`timescale 1ns/10ps
module hbdfc_ctrl_model
    import hbdfc_pkg::*;
#(
    parameter int unsigned GAP = 8  // braking cycles forced before a new drive
)(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire hbdfc_mode_t modeReq,
    output logic             legASelect,
    output logic             legBSelect
);
    hbdfc_mode_t curMode;  // mode on the pins
    int unsigned gapCnt;   // braking cycles still owed

    // clean levels, as if debounced
    assign legASelect = curMode[1];
    assign legBSelect = curMode[0];

    // every change passes through braking so ramp and fault recover
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            curMode <= HBDFC_BRAKE;
            gapCnt  <= 0;
        end
        else if (modeReq != curMode)
        begin
            if (curMode != HBDFC_BRAKE)
            begin
                curMode <= HBDFC_BRAKE;
                gapCnt  <= GAP;
            end
            else if (gapCnt != 0)
                gapCnt <= gapCnt - 1;
            else
                curMode <= modeReq;
        end
    end
endmodule : hbdfc_ctrl_model

// ### test/hbdfc_top_tb.sv
// self-checking bench for the h-bridge direction and fault control
`timescale 1ns/10ps
module hbdfc_top_tb
    import hbdfc_pkg::*;
;
    localparam int unsigned SLP  = 50;        // short sleep count
    localparam int unsigned CLR  = 5;         // short fault clear count
    localparam int unsigned GAP  = 8;         // model braking gap
    localparam int unsigned WAIT = GAP + 10;  // gap plus sync and pwm lag

    logic              clk;
    logic              nrst;
    logic              clkEn;
    logic              legASelect;
    logic              legBSelect;
    hbdfc_trips_t      trips;
    logic [RAMP_W-1:0] rampLevel;
    hbdfc_mode_t       modeReq;
    hbdfc_gates_t      gates;
    logic              faultFlagOut;
    logic              faultFlagOe_n;
    logic              faultFlag_n;  // pin level with pull-up
    logic              rampDischarge;
    logic              rampSupplyOn;
    logic              sleeping;
    int                fails;
    int                totalChecks;

    assign faultFlag_n = faultFlagOe_n ? 1'b1 : faultFlagOut;
    always #20 clk = ~clk;

    hbdfc_top #(.SLEEP_COUNT(SLP), .CLEAR_COUNT(CLR)) u_hbdfc_top (
        .clk(clk), .nrst(nrst), .clkEn(clkEn), .legASelect(legASelect),
        .legBSelect(legBSelect), .trips(trips), .rampLevel(rampLevel), .gates(gates),
        .faultFlagOut(faultFlagOut), .faultFlagOe_n(faultFlagOe_n),
        .rampDischarge(rampDischarge), .rampSupplyOn(rampSupplyOn), .sleeping(sleeping));
    hbdfc_ctrl_model #(.GAP(GAP)) u_hbdfc_ctrl_model (.clk(clk), .nrst(nrst),
        .modeReq(modeReq), .legASelect(legASelect), .legBSelect(legBSelect));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // request a mode, then wait out the gap and the pipeline
    task automatic setMode(input hbdfc_mode_t m);
        @(posedge clk);
        modeReq <= m;
        repeat (WAIT) @(posedge clk);
        @(negedge clk);
    endtask : setMode

    task automatic countPwm(input int n, output int hi, output int rises);
        logic last;
        hi = 0;
        rises = 0;
        @(negedge clk);
        last = gates.lowA;
        repeat (n)
        begin
            @(negedge clk);
            hi += (gates.lowA === 1'b1) ? 1 : 0;
            rises += (gates.lowA === 1'b1 && last === 1'b0) ? 1 : 0;
            last = gates.lowA;
        end
    endtask : countPwm

    // every mode with a full ramp, so low sides are solid
    task automatic tModes();
        logic [3:0] expG [4] = '{4'h3, 4'h6, 4'h9, 4'h0};
        for (int i = 0; i < 4; i++)
        begin
            setMode(hbdfc_mode_t'(i));
            chk("gates", expG[i], gates);
            chk("discharge", (i == 0 || i == 3), rampDischarge);
            chk("flag", 1, faultFlag_n);
        end
    endtask : tModes

    // each detector trips once on the active leg, then braking recovers
    task automatic tFault();
        for (int i = 0; i < 3; i++)
        begin
            setMode((i == 1) ? HBDFC_REV : HBDFC_FWD);
            // the earlier trip must be gone after the braking gap
            chk("cleanGates", (i == 1) ? 9 : 6, gates);
            @(posedge clk);
            trips <= hbdfc_trips_t'(3'h4 >> i);
            repeat (6) @(posedge clk);
            trips <= '0;
            repeat (4) @(negedge clk);
            chk("faultGates", (i == 1) ? 1 : 2, gates);
            chk("flag", 0, faultFlag_n);
            setMode(HBDFC_BRAKE);
            chk("flag", 1, faultFlag_n);
        end
    endtask : tFault

    // trips in braking are ignored; long braking sleeps; a drive wakes
    task automatic tSleep();
        int n;
        setMode(HBDFC_FWD);
        @(posedge clk);
        modeReq <= HBDFC_BRAKE;
        repeat (4) @(posedge clk);
        trips <= 3'h7;
        n = 4;
        while (sleeping !== 1'b1 && n < SLP + 20)
        begin
            @(negedge clk);
            n++;
        end
        chk("sleepDelay", 1, n >= SLP && n <= SLP + 10);
        chk("sleepGates", 3, gates);
        chk("supply", 0, rampSupplyOn);
        chk("flag", 1, faultFlag_n);
        // trips stand until the very edge the drive starts, so a latch in brake would show
        @(posedge clk);
        modeReq <= HBDFC_FWD;
        wait (legBSelect === 1'b1);
        trips <= '0;
        repeat (WAIT) @(posedge clk);
        @(negedge clk);
        chk("wakeGates", 6, gates);
        chk("sleeping", 0, sleeping);
        chk("supply", 1, rampSupplyOn);
    endtask : tSleep

    // ramp codes below, above and inside the switching band; steady only
    task automatic tPwm();
        int hi;
        int rises;
        @(posedge clk);
        rampLevel <= 8'h00;
        repeat (8) @(posedge clk);
        countPwm(OSC_CYC, hi, rises);
        chk("pwmLow", 0, hi);
        @(posedge clk);
        rampLevel <= 8'hF0;
        repeat (8) @(posedge clk);
        countPwm(OSC_CYC, hi, rises);
        chk("pwmHigh", OSC_CYC, hi);
        @(posedge clk);
        rampLevel <= 8'h8A;
        repeat (8) @(posedge clk);
        countPwm(2 * OSC_CYC, hi, rises);
        chk("pwmRises", 2, rises);
        chk("pwmDuty", 1, hi > 0 && hi < 2 * OSC_CYC);
        setMode(HBDFC_COAST);
        chk("gates", 0, gates);
    endtask : tPwm

    task automatic stopTest();
        $display("checks %0d errors %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stopTest

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        clkEn = 1'b1;
        trips = '0;
        rampLevel = 8'hFF;
        modeReq = HBDFC_BRAKE;
        fails = 0;
        totalChecks = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        tModes();
        tFault();
        tSleep();
        tPwm();
        stopTest();
    end

    // run needs about 5400 cycles; allow nearly four times that
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        stopTest();
    end
endmodule : hbdfc_top_tb
